//--- sercfg_pkg.sv
// package: register map, field layout and timing constants for i2c config
package sercfg_pkg;
  // register offsets
  localparam logic [7:0] ADDR_MASTER_CFG = 8'h0f;
  localparam logic [7:0] ADDR_COND_CTRL = 8'h10;
  // master configuration fields
  localparam int DLY_LSB = 3;
  localparam int BLK_BIT = 2;
  localparam int SPD_BIT = 1;
  localparam int DIS_BIT = 0;
  localparam logic [7:0] MASTER_CFG_MASK = 8'h1f;
  localparam logic [7:0] MASTER_CFG_RST = 8'h00;
  // input conditioning fields
  localparam int HOLD_LSB = 4;
  localparam int FILT_LSB = 0;
  localparam logic [7:0] COND_CTRL_MASK = 8'h7f;
  localparam logic [7:0] COND_CTRL_RST = 8'h17;
  // timing in ns, the core clock period, derived cycle counts and the recovery pulse count
  localparam int CLK_NS = 5;
  localparam int SDA_DLY_BASE_NS = 350;
  localparam int SDA_DLY_STEP_NS = 50;
  localparam int HOLD_STEP_NS = 50;
  localparam int FILT_STEP_NS = 10;
  localparam int WD_FAST_NS = 50000;
  localparam int WD_SLOW_NS = 1000000000;
  localparam int REC_HALF_NS = 5000;
  localparam int REC_PULSES = 9;
  localparam int DLY_BASE_CYC = SDA_DLY_BASE_NS / CLK_NS;
  localparam int DLY_STEP_CYC = SDA_DLY_STEP_NS / CLK_NS;
  localparam int HOLD_STEP_CYC = HOLD_STEP_NS / CLK_NS;
  localparam int FILT_STEP_CYC = FILT_STEP_NS / CLK_NS;
  // a register write crossing from the control channel
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } sercfg_wr_type;
  // recovery sequencer states
  typedef enum logic [1:0] {
    REC_IDLE,
    REC_LOW,
    REC_HIGH
  } sercfg_rec_type;
endpackage : sercfg_pkg

//--- sercfg_i2c_cfg.sv
// i2c bus configuration: registers, input conditioning, sda delay, watchdog
// Operation
// R1: sda output delay code selects 350, 400, 450 or 500 ns after scl.
// R2: remote-write-block bit set refuses far-side writes to local registers.
// R3: block leaves remote pass-through accesses to local bus slaves alone.
// R4: watchdog expires after 50 us with speed-up set, else one second.
// R5: watchdog disable bit set stops the bus watchdog.
// R6: sda high with no activity for the timeout means the bus is free.
// R7: sda stuck low with no activity: drive nine scl clock pulses.
// R8: three-bit hold field holds internal sda after scl in 50 ns steps.
// R9: four-bit filter field rejects scl/sda glitches up to n times 10 ns.
// R10: reserved bits read as zero and ignore writes.
`timescale 1ns/100ps

// glitch filter: output follows input only once it has stood past the limit
module sercfg_glitch_filter #(
  parameter int CW = 6
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // async reset, high
  input wire logic i_raw, // synchronised pin level
  input wire logic [CW-1:0] i_limit, // widest rejected pulse, cycles
  output logic o_filt // filtered level
);
  logic [CW-1:0] cnt_r;
  wire differs = (i_raw != o_filt);
  wire expired = (cnt_r >= i_limit);

  // a pulse no longer than the limit never reaches the output
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
      o_filt <= 1'b1;
    end else if (!differs) begin
      cnt_r <= '0;
    end else if (expired) begin
      o_filt <= i_raw; // [R9]
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : sercfg_glitch_filter

module sercfg_i2c_cfg #(
  parameter int WD_FAST_CYC = sercfg_pkg::WD_FAST_NS / sercfg_pkg::CLK_NS,
  parameter int WD_SLOW_CYC = sercfg_pkg::WD_SLOW_NS / sercfg_pkg::CLK_NS,
  parameter int REC_HALF_CYC = sercfg_pkg::REC_HALF_NS / sercfg_pkg::CLK_NS
) (
  input wire logic i_clk, // core clock, 200 MHz
  input wire logic i_rst, // async reset, high
  input wire logic i_reg_wr, // local register write strobe
  input wire logic [7:0] i_reg_addr, // local register address
  input wire logic [7:0] i_reg_wdata, // local write data
  output logic [7:0] o_reg_rdata, // read data, one cycle after address
  input wire logic i_link_clk, // control channel clock
  input wire logic i_lnk_wr_valid, // remote register write request
  input wire sercfg_pkg::sercfg_wr_type i_lnk_wr, // remote address/data
  output logic o_lnk_wr_ready, // link side may present a request
  output logic o_lnk_wr_refused, // last remote write was blocked
  input wire logic i_scl_i, // scl pin level
  input wire logic i_sda_i, // sda pin level
  input wire logic i_sda_drive, // engine wants sda low
  output logic o_scl_int, // conditioned scl to the engine
  output logic o_sda_int, // conditioned, held sda to the engine
  output logic o_scl_o, // scl output value
  output logic o_scl_oe, // scl driven low when high
  output logic o_sda_o, // sda output value
  output logic o_sda_oe, // sda driven low when high
  output logic o_bus_free, // watchdog found the bus idle and free
  output logic o_bus_recover // nine-pulse recovery in progress
);
  import sercfg_pkg::*;

  logic [7:0] mcfg_r, cond_r;
  // remote write crossing, link domain
  logic lreq_tgl_r, lack_s1_r, lack_s2_r, lrefused_r;
  sercfg_wr_type lwr_r;
  // remote write crossing, core domain
  logic creq_s1_r, creq_s2_r, creq_seen_r, cack_tgl_r, cref_r;
  logic cref_s1_r, cref_s2_r;
  // pin synchronisers and conditioning
  logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
  logic scl_f, sda_f, scl_d_r, sda_d_r, sda_hold_r;
  logic [6:0] hold_cnt_r;
  logic [7:0] dly_cnt_r;
  logic [31:0] wd_cnt_r;
  logic [3:0] pulse_cnt_r;
  logic [15:0] half_cnt_r;
  sercfg_rec_type rec_r, rec_nxt;

  // field decode
  wire [1:0] dly_code = mcfg_r[DLY_LSB +: 2];
  wire blk_remote = mcfg_r[BLK_BIT];
  wire wd_fast = mcfg_r[SPD_BIT];
  wire wd_off = mcfg_r[DIS_BIT];
  wire [2:0] hold_code = cond_r[HOLD_LSB +: 3];
  wire [3:0] filt_code = cond_r[FILT_LSB +: 4];
  wire [7:0] dly_cyc = 8'(DLY_BASE_CYC) + 8'(dly_code) * 8'(DLY_STEP_CYC); // [R1]
  wire [6:0] hold_cyc = 7'(hold_code) * 7'(HOLD_STEP_CYC); // [R8]
  wire [5:0] filt_cyc = 6'(filt_code) * 6'(FILT_STEP_CYC); // [R9]

  // remote write handling; local bus pass-through never comes this way
  wire rem_new = (creq_s2_r != creq_seen_r);
  wire rem_go = rem_new && !i_reg_wr; // local write first, remote waits
  wire rem_ok = rem_go && !blk_remote; // [R2] [R3]
  wire wr_en = i_reg_wr || rem_ok;
  wire [7:0] wr_addr = i_reg_wr ? i_reg_addr : lwr_r.addr;
  wire [7:0] wr_data = i_reg_wr ? i_reg_wdata : lwr_r.data;
  wire wr_mcfg = wr_en && (wr_addr == ADDR_MASTER_CFG);
  wire wr_cond = wr_en && (wr_addr == ADDR_COND_CTRL);
  wire [7:0] rd_mux = (i_reg_addr == ADDR_MASTER_CFG) ? mcfg_r :
                      (i_reg_addr == ADDR_COND_CTRL) ? cond_r : 8'h00;

  // config registers; reserved bits are masked on write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mcfg_r <= MASTER_CFG_RST;
      cond_r <= COND_CTRL_RST;
    end else begin
      if (wr_mcfg) mcfg_r <= wr_data & MASTER_CFG_MASK; // [R10] [R5]
      if (wr_cond) cond_r <= wr_data & COND_CTRL_MASK; // [R10]
    end
  end

  // read data is registered so the output is a flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_reg_rdata <= 8'h00;
    else o_reg_rdata <= rd_mux;
  end

  // link side: toggle request, data held stable until ack returns
  wire lnk_idle = (lreq_tgl_r == lack_s2_r);
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      lreq_tgl_r <= 1'b0;
      lwr_r <= '0;
      lack_s1_r <= 1'b0;
      lack_s2_r <= 1'b0;
      cref_s1_r <= 1'b0;
      cref_s2_r <= 1'b0;
      lrefused_r <= 1'b0;
      o_lnk_wr_ready <= 1'b0;
    end else begin
      lack_s1_r <= cack_tgl_r;
      lack_s2_r <= lack_s1_r;
      cref_s1_r <= cref_r;
      cref_s2_r <= cref_s1_r;
      o_lnk_wr_ready <= lnk_idle && !(i_lnk_wr_valid && o_lnk_wr_ready);
      if (i_lnk_wr_valid && o_lnk_wr_ready) begin
        lwr_r <= i_lnk_wr;
        lreq_tgl_r <= ~lreq_tgl_r;
      end
      if (lnk_idle) lrefused_r <= cref_s2_r;
    end
  end
  assign o_lnk_wr_refused = lrefused_r;

  // core side: sync request toggle, perform write, return ack toggle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      creq_s1_r <= 1'b0;
      creq_s2_r <= 1'b0;
      creq_seen_r <= 1'b0;
      cack_tgl_r <= 1'b0;
      cref_r <= 1'b0;
    end else begin
      creq_s1_r <= lreq_tgl_r;
      creq_s2_r <= creq_s1_r;
      if (rem_go) begin
        creq_seen_r <= creq_s2_r;
        cack_tgl_r <= ~cack_tgl_r;
        cref_r <= blk_remote; // [R2]
      end
    end
  end

  // pin synchronisers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      scl_s1_r <= i_scl_i;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= i_sda_i;
      sda_s2_r <= sda_s1_r;
    end
  end

  sercfg_glitch_filter #(.CW(6)) u_scl_filt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_raw(scl_s2_r),
    .i_limit(filt_cyc),
    .o_filt(scl_f)
  );

  sercfg_glitch_filter #(.CW(6)) u_sda_filt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_raw(sda_s2_r),
    .i_limit(filt_cyc),
    .o_filt(sda_f)
  );

  wire scl_fall = scl_d_r && !scl_f;
  wire activity = (scl_d_r != scl_f) || (sda_d_r != sda_f);

  // hold: after scl falls, internal sda keeps its value for hold cycles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      hold_cnt_r <= '0;
      sda_hold_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
      if (scl_fall) hold_cnt_r <= hold_cyc; // [R8]
      else if (hold_cnt_r != '0) hold_cnt_r <= hold_cnt_r - 1'b1;
      if (!scl_fall && hold_cnt_r == '0) sda_hold_r <= sda_f;
    end
  end
  assign o_scl_int = scl_d_r;
  assign o_sda_int = sda_hold_r;

  // sda output changes only once the delay after scl falling has passed
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dly_cnt_r <= '0;
      o_sda_oe <= 1'b0;
      o_sda_o <= 1'b0;
    end else begin
      if (scl_fall) dly_cnt_r <= dly_cyc; // [R1]
      else if (dly_cnt_r != '0) dly_cnt_r <= dly_cnt_r - 1'b1;
      if (!scl_fall && dly_cnt_r == '0) o_sda_oe <= i_sda_drive; // [R1]
    end
  end

  // watchdog: counts idle cycles, cleared by any bus edge
  wire [31:0] wd_lim = wd_fast ? 32'(WD_FAST_CYC) : 32'(WD_SLOW_CYC); // [R4]
  wire wd_run = !wd_off && (rec_r == REC_IDLE); // [R5]
  wire wd_hit = wd_run && (wd_cnt_r >= wd_lim); // [R4]
  wire half_done = (half_cnt_r >= 16'(REC_HALF_CYC - 1));
  wire last_pulse = (pulse_cnt_r == 4'(REC_PULSES - 1));

  // recovery sequencer: low half, high half, nine times
  always_comb begin
    rec_nxt = rec_r;
    case (rec_r)
      REC_IDLE: if (wd_hit && !sda_f) rec_nxt = REC_LOW; // [R7]
      REC_LOW: if (half_done) rec_nxt = REC_HIGH;
      REC_HIGH: if (half_done) rec_nxt = last_pulse ? REC_IDLE : REC_LOW;
      default: rec_nxt = REC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rec_r <= REC_IDLE;
      half_cnt_r <= '0;
      pulse_cnt_r <= '0;
    end else begin
      rec_r <= rec_nxt;
      half_cnt_r <= (rec_nxt != rec_r) ? '0 : half_cnt_r + 1'b1;
      if (rec_r == REC_IDLE) pulse_cnt_r <= '0;
      else if (rec_r == REC_HIGH && half_done) pulse_cnt_r <= pulse_cnt_r + 1'b1; // [R7]
    end
  end

  // watchdog counter and free flag; a long idle period must not wrap
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wd_cnt_r <= '0;
      o_bus_free <= 1'b0;
      o_scl_oe <= 1'b0;
      o_scl_o <= 1'b0;
      o_bus_recover <= 1'b0;
    end else begin
      if (!wd_run || activity || wd_hit) wd_cnt_r <= '0;
      else wd_cnt_r <= wd_cnt_r + 1'b1;
      if (activity || wd_off) o_bus_free <= 1'b0;
      else if (wd_hit && sda_f) o_bus_free <= 1'b1; // [R6]
      o_scl_oe <= (rec_nxt == REC_LOW); // [R7]
      o_bus_recover <= (rec_nxt != REC_IDLE);
    end
  end
endmodule : sercfg_i2c_cfg

//--- sercfg_i2c_cfg_props.sv
// checker: port-level properties of the i2c config block
`timescale 1ns/100ps
module sercfg_i2c_cfg_props #(
  parameter int REC_HALF_CYC = 4
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // reset
  input wire logic i_link_clk, // link clock
  input wire logic [7:0] i_reg_addr, // address
  input wire logic [7:0] o_reg_rdata, // read data
  input wire logic i_lnk_wr_valid, // remote request
  input wire logic o_lnk_wr_ready, // remote ready
  input wire logic o_scl_int, // filtered scl
  input wire logic o_sda_int, // filtered sda
  input wire logic o_scl_oe, // scl pull
  input wire logic o_sda_oe, // sda pull
  input wire logic o_bus_free, // bus free
  input wire logic o_bus_recover // recovery
);
  import sercfg_pkg::*;
  logic [9:0] fall_r; // cycles since scl fell, saturating
  logic [7:0] hi_r; // length of current scl pull
  logic [3:0] pul_r; // pulls within one recovery
  // saturation keeps an old fall from wrapping into a short count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fall_r <= 10'h3ff;
      hi_r <= 8'h00;
      pul_r <= 4'h0;
    end else begin
      if ($fell(o_scl_int)) fall_r <= 10'h000;
      else if (fall_r != 10'h3ff) fall_r <= fall_r + 10'h001;
      hi_r <= o_scl_oe ? hi_r + 8'h01 : 8'h00;
      if (!o_bus_recover) pul_r <= 4'h0;
      else if ($rose(o_scl_oe)) pul_r <= pul_r + 4'h1;
    end
  end
  a_cfg_rsvd_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_reg_addr) == 8'h0f |-> o_reg_rdata[7:5] == 3'h0)
    else $error("master cfg reserved bits set");
  a_cond_rsvd_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_reg_addr) == 8'h10 |-> !o_reg_rdata[7])
    else $error("conditioning reserved bit set");
  a_free_sda_high: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_bus_free) |-> o_sda_int)
    else $error("bus free with sda low");
  a_scl_pull_recover: assert property (@(posedge i_clk) disable iff (i_rst)
    o_scl_oe |-> o_bus_recover)
    else $error("scl pulled outside recovery");
  a_pull_width: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_scl_oe) |-> hi_r == REC_HALF_CYC)
    else $error("recovery low phase wrong length");
  a_nine_pulses: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_bus_recover) |-> pul_r == 4'h9)
    else $error("recovery pulse count wrong");
  a_sda_out_delay: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(o_sda_oe) |-> fall_r >= 10'h044)
    else $error("sda changed too soon after scl fall");
  a_ready_drop: assert property (@(posedge i_link_clk) disable iff (i_rst)
    i_lnk_wr_valid && o_lnk_wr_ready |=> !o_lnk_wr_ready)
    else $error("ready stayed high after request");
  c_free: cover property (@(posedge i_clk) $rose(o_bus_free));
  c_recover: cover property (@(posedge i_clk) $fell(o_bus_recover));
  c_sda: cover property (@(posedge i_clk) $rose(o_sda_oe));
endmodule : sercfg_i2c_cfg_props

bind sercfg_i2c_cfg sercfg_i2c_cfg_props #(.REC_HALF_CYC(REC_HALF_CYC))
  sercfg_i2c_cfg_props_i (.i_clk, .i_rst, .i_link_clk, .i_reg_addr,
  .o_reg_rdata, .i_lnk_wr_valid, .o_lnk_wr_ready, .o_scl_int, .o_sda_int,
  .o_scl_oe, .o_sda_oe, .o_bus_free, .o_bus_recover);

//--- sercfg_slave_model.sv
// partner: local i2c slave on open-drain pins, able to hang sda low
`timescale 1ns/100ps
module sercfg_slave_model (
  input wire logic i_scl_oe, // device pulls scl
  input wire logic i_sda_oe, // device pulls sda
  input wire logic i_scl_low, // bench pulls scl
  input wire logic i_hang, // slave starts holding sda
  input wire logic i_sda_low, // bench pulls sda
  output logic o_scl, // scl wire
  output logic o_sda // sda wire
);
  logic stuck_r = 1'h0;
  int edges_r = 0;
  // wired-and with pull-ups: a released line goes high
  assign o_scl = !(i_scl_oe || i_scl_low);
  assign o_sda = !(i_sda_oe || stuck_r || i_sda_low);
  // a hung slave only lets go once enough clocks shift it out
  always @(posedge i_hang or posedge o_scl) begin
    if (i_hang && !stuck_r && edges_r == 0) stuck_r = 1'h1;
    else if (stuck_r) edges_r = edges_r + 1;
    if (edges_r >= 9) stuck_r = 1'h0;
  end
endmodule : sercfg_slave_model

//--- sercfg_i2c_cfg_tb_top.sv
// testbench: registers, remote writes, filter, delay, watchdog
`timescale 1ns/100ps
module sercfg_i2c_cfg_tb_top;
  import sercfg_pkg::*;
  logic i_clk = 1'h0, i_rst = 1'h1, i_link_clk = 1'h0, i_reg_wr = 1'h0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic i_lnk_wr_valid = 1'h0, i_sda_drive = 1'h0, scl_low = 1'h0;
  logic hang = 1'h0, lo_seen = 1'h0, o_lnk_wr_ready, o_lnk_wr_refused;
  logic sda_low = 1'h0;
  logic i_scl_i, i_sda_i, o_scl_int, o_sda_int, o_scl_o, o_scl_oe;
  logic o_sda_o, o_sda_oe, o_bus_free, o_bus_recover;
  sercfg_wr_type i_lnk_wr = 16'h0000;
  int n_errors = 0, total_checks = 0, cyc = 0, n;
  sercfg_i2c_cfg #(.WD_FAST_CYC(200), .WD_SLOW_CYC(400), .REC_HALF_CYC(4))
    sercfg_i2c_cfg_i (.i_clk, .i_rst, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .i_link_clk, .i_lnk_wr_valid, .i_lnk_wr, .o_lnk_wr_ready,
    .o_lnk_wr_refused, .i_scl_i, .i_sda_i, .i_sda_drive, .o_scl_int,
    .o_sda_int, .o_scl_o, .o_scl_oe, .o_sda_o, .o_sda_oe, .o_bus_free,
    .o_bus_recover);
  sercfg_slave_model sercfg_slave_model_i (.i_scl_oe(o_scl_oe),
    .i_sda_oe(o_sda_oe), .i_scl_low(scl_low), .i_hang(hang),
    .i_sda_low(sda_low),
    .o_scl(i_scl_i), .o_sda(i_sda_i));
  always #2.5 i_clk = ~i_clk;
  // link clock offset so its edges never line up with the core clock
  initial begin
    #13.3;
    forever #62.5 i_link_clk = ~i_link_clk;
  end
  // cycle ceiling, plus a latch of any low on filtered scl
  always @(posedge i_clk) begin
    cyc++;
    if (o_scl_int === 1'h0) lo_seen <= 1'h1;
    if (cyc == 40000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic sig(input int s);
    case (s)
      0: return o_bus_free;
      1: return o_bus_recover;
      2: return o_scl_int;
      default: return o_sda_oe;
    endcase
  endfunction : sig
  // bounded wait; n holds the cycles spent
  task automatic wt(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(posedge i_clk);
      n++;
    end
  endtask : wt
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_clk) #1;
    i_reg_wr = 1'h1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(posedge i_clk) #1;
    i_reg_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    @(posedge i_clk) #1;
    i_reg_addr = a;
    repeat (2) @(posedge i_clk);
    #1 chk("rdata", o_reg_rdata, exp);
  endtask : rd
  // remote write held until ready is sampled, then wait for completion
  task automatic rw(input logic [7:0] a, d);
    int k;
    @(posedge i_link_clk) #1;
    i_lnk_wr_valid = 1'h1;
    i_lnk_wr = {a, d};
    k = 0;
    // valid must stand across the edge that sees ready high
    do begin
      @(posedge i_link_clk);
      k++;
    end while (o_lnk_wr_ready !== 1'h1 && k < 20);
    #1 i_lnk_wr_valid = 1'h0;
    for (k = 0; k < 20 && o_lnk_wr_ready !== 1'h1; k++)
      @(posedge i_link_clk);
    #1 chk("lnk_ready", {7'h00, o_lnk_wr_ready}, 8'h01);
  endtask : rw
  task automatic pull(input int c);
    @(posedge i_clk) #1;
    scl_low = 1'h1;
    repeat (c) @(posedge i_clk);
    #1 scl_low = 1'h0;
  endtask : pull
  task automatic t_regs();
    rd(8'h0f, 8'h00);
    rd(8'h10, 8'h17);
    wr(8'h0f, 8'hff);
    wr(8'h10, 8'hff);
    wr(8'h11, 8'hff);
    rd(8'h0f, 8'h1f);
    rd(8'h10, 8'h7f);
    rd(8'h11, 8'h00);
    wr(8'h0f, 8'h04);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_remote();
    rw(8'h10, 8'h22);
    chk("refused", {7'h00, o_lnk_wr_refused}, 8'h01);
    rw(8'h0f, 8'h00);
    rd(8'h0f, 8'h04);
    rd(8'h10, 8'h7f);
    wr(8'h0f, 8'h00);
    rw(8'h10, 8'h22);
    chk("refused", {7'h00, o_lnk_wr_refused}, 8'h00);
    rd(8'h10, 8'h22);
    $display("t_remote done");
  endtask : t_remote
  // 14 cycles is the widest rejected pulse at filter code 7
  task automatic t_filter();
    wr(8'h10, 8'h17);
    lo_seen = 1'h0;
    pull(14);
    repeat (40) @(posedge i_clk);
    chk("glitch", {7'h00, lo_seen}, 8'h00);
    pull(17);
    repeat (6) @(posedge i_clk);
    chk("pulse", {7'h00, lo_seen}, 8'h01);
    wr(8'h10, 8'h10);
    repeat (40) @(posedge i_clk);
    lo_seen = 1'h0;
    pull(4);
    repeat (20) @(posedge i_clk);
    chk("nofilt", {7'h00, lo_seen}, 8'h01);
    wr(8'h10, 8'h17);
    $display("t_filter done");
  endtask : t_filter
  task automatic t_dly();
    for (int c = 0; c < 4; c++) begin
      wr(8'h0f, 8'(c << 3));
      scl_low = 1'h1;
      wt(2, 1'h0, 50);
      #1 i_sda_drive = 1'h1;
      wt(3, 1'h1, 300);
      chk("sda_dly", {7'h00, n >= 66 + 10 * c && n <= 73 + 10 * c}, 8'h01);
      #1 i_sda_drive = 1'h0;
      scl_low = 1'h0;
      repeat (150) @(posedge i_clk);
    end
    $display("t_dly done");
  endtask : t_dly
  // sda falls just after scl: internal sda keeps its old level 30 cycles
  task automatic t_hold();
    wr(8'h10, 8'h30);
    scl_low = 1'h1;
    wt(2, 1'h0, 50);
    #1 sda_low = 1'h1;
    repeat (20) @(posedge i_clk);
    #1 chk("hold_on", {7'h00, o_sda_int}, 8'h01);
    repeat (15) @(posedge i_clk);
    #1 chk("hold_off", {7'h00, o_sda_int}, 8'h00);
    sda_low = 1'h0;
    scl_low = 1'h0;
    wr(8'h10, 8'h17);
    repeat (60) @(posedge i_clk);
    $display("t_hold done");
  endtask : t_hold
  task automatic t_wd();
    wr(8'h0f, 8'h02);
    pull(20);
    wt(0, 1'h1, 700);
    chk("wd_fast", {7'h00, n >= 190 && n <= 245}, 8'h01);
    wr(8'h0f, 8'h00);
    pull(20);
    wt(0, 1'h1, 700);
    chk("wd_slow", {7'h00, n >= 390 && n <= 445}, 8'h01);
    $display("t_wd done");
  endtask : t_wd
  task automatic t_rec();
    wr(8'h0f, 8'h03);
    hang = 1'h1;
    repeat (600) @(posedge i_clk);
    chk("dis_rec", {7'h00, o_bus_recover}, 8'h00);
    chk("dis_free", {7'h00, o_bus_free}, 8'h00);
    wr(8'h0f, 8'h02);
    wt(1, 1'h1, 400);
    chk("recover", {7'h00, o_bus_recover}, 8'h01);
    wt(1, 1'h0, 200);
    chk("sda_free", {7'h00, i_sda_i}, 8'h01);
    hang = 1'h0;
    $display("t_rec done");
  endtask : t_rec
  // reset spans two link clock edges as well as the core ones
  initial begin
    repeat (50) @(posedge i_clk);
    #1 i_rst = 1'h0;
    t_regs();
    t_remote();
    t_filter();
    t_dly();
    t_hold();
    t_wd();
    t_rec();
    close_out();
  end
endmodule : sercfg_i2c_cfg_tb_top
